//--- hdl/spms_sensor.sv
// Purpose: Operating-mode sequencer of the image sensor end
// Assumes: Pins come from host logic on the same clock
// Notes:   Long waits counted in reference ticks
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module spms_sensor
  import spms_pkg::*;
#(
  parameter int unsigned BOOT_TICKS  = BOOT_REF_CYC,
  parameter int unsigned WAKE_TICKS  = WAKE_REF_CYC,
  parameter int unsigned PLL_TICKS   = PLL_REF_CYC,
  parameter int unsigned INTEG_TICKS = INTEG_REF_CYC,
  parameter int unsigned FRAME_TICKS = FRAME_REF_CYC
) (
  input  logic       clk_i,
  input  logic       rst_i,
  spms_if.device     link,
  output spms_mode_e mode_o,
  output logic       pll_on_o,
  output logic       analog_on_o,
  output logic       pll_clk_sel_o,
  output logic       regulator_lp_o,
  output logic       clocks_gated_o,
  output logic       video_valid_o
);
  spms_mode_e       state_r;
  spms_mode_e       state_nxt;
  logic             stream_en_r;
  logic             pad_val_r;
  logic             pad_en_r;
  logic             cnt_start_r;
  logic [CNT_W-1:0] cnt_len_r;
  logic             cnt_done;
  logic             cnt_end;
  logic             ref_tick;
  logic             bus_on;
  logic             swrst_hit;
  logic             frame_end;
  logic             load_cnt;

  // Reference clock blocked from logic in power down
  assign ref_tick  = link.reference_clock_in && (state_r != ST_POWER_DOWN);
  // Control bus only alive once standby is reached
  assign bus_on    = state_r inside {ST_STANDBY, ST_PLL_LOCK, ST_INTEGRATE, ST_STREAM};
  assign swrst_hit = bus_on && link.ctl_wr && (link.ctl_addr == SWRST_REG_ADDR)
                     && link.ctl_wdata[SWRST_BIT];
  // Ignore a stale done in the reload cycle
  assign cnt_end   = cnt_done && !cnt_start_r;
  assign frame_end = (state_r == ST_STREAM) && cnt_end;

  spms_tick_cnt #(
    .W (CNT_W)
  ) u_wait (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (cnt_start_r),
    .len_i   (cnt_len_r),
    .tick_i  (ref_tick),
    .busy_o  (),
    .done_o  (cnt_done)
  );

  // Mode selection
  always_comb begin
    state_nxt = state_r;
    if (!link.hard_reset_pin_n) begin
      state_nxt = ST_HARDWARE_RESET_STATE;
    end else if (swrst_hit) begin
      state_nxt = ST_SOFTWARE_RESET_STATE;
    end else begin
      case (state_r)
        ST_HARDWARE_RESET_STATE: begin
          state_nxt = ST_BOOT;
        end
        ST_BOOT: begin
          if (cnt_end) begin
            state_nxt = ST_SOFTWARE_RESET_STATE;
          end
        end
        ST_SOFTWARE_RESET_STATE: begin
          state_nxt = ST_STANDBY;
        end
        ST_STANDBY: begin
          if (!link.power_down_pin_n) begin
            state_nxt = ST_POWER_DOWN;
          end else if (stream_en_r) begin
            state_nxt = ST_PLL_LOCK;
          end
        end
        ST_POWER_DOWN: begin
          if (link.power_down_pin_n) begin
            state_nxt = ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (cnt_end) begin
            state_nxt = ST_SOFTWARE_RESET_STATE;
          end
        end
        ST_PLL_LOCK: begin
          if (cnt_end) begin
            state_nxt = ST_INTEGRATE;
          end
        end
        ST_INTEGRATE: begin
          if (cnt_end) begin
            state_nxt = ST_STREAM;
          end
        end
        ST_STREAM: begin
          if (frame_end && !stream_en_r) begin
            state_nxt = ST_STANDBY;
          end
        end
        default: begin
          state_nxt = ST_HARDWARE_RESET_STATE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_HARDWARE_RESET_STATE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Wait counter loads on entry and on each new frame
  assign load_cnt = (state_nxt != state_r) || (frame_end && state_nxt == ST_STREAM);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_start_r <= 1'b0;
      cnt_len_r   <= '0;
    end else begin
      cnt_start_r <= 1'b0;
      if (load_cnt) begin
        case (state_nxt)
          ST_BOOT: begin
            cnt_start_r <= 1'b1;
            cnt_len_r   <= CNT_W'(BOOT_TICKS);
          end
          ST_WAKE: begin
            cnt_start_r <= 1'b1;
            cnt_len_r   <= CNT_W'(WAKE_TICKS);
          end
          ST_PLL_LOCK: begin
            cnt_start_r <= 1'b1;
            cnt_len_r   <= CNT_W'(PLL_TICKS);
          end
          ST_INTEGRATE: begin
            cnt_start_r <= 1'b1;
            cnt_len_r   <= CNT_W'(INTEG_TICKS);
          end
          ST_STREAM: begin
            cnt_start_r <= 1'b1;
            cnt_len_r   <= CNT_W'(FRAME_TICKS);
          end
          default: begin
            cnt_start_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Register file; defaults on hardware and software reset
  always_ff @(posedge clk_i) begin
    if (rst_i || state_nxt == ST_HARDWARE_RESET_STATE || state_nxt == ST_SOFTWARE_RESET_STATE) begin
      stream_en_r <= STREAM_EN_RST;
      pad_val_r   <= PAD_VAL_RST;
      pad_en_r    <= PAD_EN_RST;
    end else if (bus_on && link.ctl_wr) begin
      if (link.ctl_addr == STREAM_REG_ADDR) begin
        stream_en_r <= link.ctl_wdata[STREAM_EN_BIT];
      end
      if (link.ctl_addr == PAD_REG_ADDR) begin
        pad_val_r <= link.ctl_wdata[PAD_VAL_BIT];
        pad_en_r  <= link.ctl_wdata[PAD_EN_BIT];
      end
    end
  end

  // Read data one cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.ctl_rdata <= 8'h00;
    end else begin
      link.ctl_rdata <= 8'h00;
      if (bus_on && link.ctl_rd) begin
        case (link.ctl_addr)
          STREAM_REG_ADDR: link.ctl_rdata[STREAM_EN_BIT] <= stream_en_r;
          PAD_REG_ADDR: begin
            link.ctl_rdata[PAD_VAL_BIT] <= pad_val_r;
            link.ctl_rdata[PAD_EN_BIT]  <= pad_en_r;
          end
          MODE_REG_ADDR: link.ctl_rdata[3:0] <= state_r;
          default: link.ctl_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Power and clock controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_o         <= ST_HARDWARE_RESET_STATE;
      pll_on_o       <= 1'b0;
      analog_on_o    <= 1'b0;
      pll_clk_sel_o  <= 1'b0;
      regulator_lp_o <= 1'b0;
      clocks_gated_o <= 1'b1;
      video_valid_o  <= 1'b0;
    end else begin
      mode_o         <= state_nxt;
      pll_on_o       <= state_nxt inside {ST_PLL_LOCK, ST_INTEGRATE, ST_STREAM};
      analog_on_o    <= state_nxt inside {ST_PLL_LOCK, ST_INTEGRATE, ST_STREAM};
      pll_clk_sel_o  <= state_nxt inside {ST_INTEGRATE, ST_STREAM};
      regulator_lp_o <= state_nxt == ST_POWER_DOWN;
      clocks_gated_o <= state_nxt inside {ST_HARDWARE_RESET_STATE, ST_POWER_DOWN, ST_WAKE};
      video_valid_o  <= state_nxt == ST_STREAM;
    end
  end

  // Frame sync and configurable pads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.frame_sync <= 1'b0;
      link.pad_val    <= 1'b0;
      link.pad_oe     <= 1'b0;
    end else begin
      link.frame_sync <= frame_end;
      case (state_nxt)
        ST_HARDWARE_RESET_STATE, ST_BOOT: begin
          link.pad_val <= 1'b0;
          link.pad_oe  <= 1'b0;
        end
        ST_STREAM: begin
          link.pad_val <= 1'b0;
          link.pad_oe  <= 1'b1;
        end
        default: begin
          link.pad_val <= pad_val_r && pad_en_r;
          link.pad_oe  <= pad_en_r;
        end
      endcase
    end
  end
endmodule

//--- hdl/spms_pkg.sv
// Purpose: Shared constants and types of the sensor mode sequencer
// Assumes: 100 MHz system clock, reference clock as an enable pulse
// Notes:   Counts in reference ticks when named _REF_CYC, in clocks when named _WAIT_CYC
package spms_pkg;
  // Reference clock tick counts and reference clock divider
  localparam int unsigned BOOT_REF_CYC  = 9500;
  localparam int unsigned WAKE_REF_CYC  = 32767;
  localparam int unsigned PLL_REF_CYC   = 4096;
  localparam int unsigned INTEG_REF_CYC = 64;
  localparam int unsigned FRAME_REF_CYC = 256;
  localparam int unsigned REF_CLK_DIV   = 4;
  // Host wait after software reset
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned SWRST_WAIT_MS  = 10;
  localparam int unsigned SWRST_WAIT_CYC = SWRST_WAIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W          = 20;
  // Device register map
  localparam logic [15:0] STREAM_REG_ADDR  = 16'h3012;
  localparam logic [15:0] SWRST_REG_ADDR   = 16'h3013;
  localparam logic [15:0] PAD_REG_ADDR     = 16'h3488;
  localparam logic [15:0] MODE_REG_ADDR    = 16'h30F0;
  localparam logic [15:0] HIGH_REGION_ADDR = 16'h7000;
  localparam int unsigned STREAM_EN_BIT    = 0;
  localparam int unsigned SWRST_BIT        = 0;
  localparam int unsigned PAD_VAL_BIT      = 5;
  localparam int unsigned PAD_EN_BIT       = 4;
  localparam logic        STREAM_EN_RST    = 1'b0;
  localparam logic        PAD_VAL_RST      = 1'b0;
  localparam logic        PAD_EN_RST       = 1'b0;
  // Host register map
  localparam logic [7:0]  HC_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  HC_ADDR_OFS   = 8'h04;
  localparam logic [7:0]  HC_WDATA_OFS  = 8'h08;
  localparam logic [7:0]  HC_RDATA_OFS  = 8'h0C;
  localparam logic [7:0]  HC_STATUS_OFS = 8'h10;
  localparam int unsigned CTRL_REL_BIT  = 0;
  localparam int unsigned CTRL_PWR_BIT  = 1;
  localparam int unsigned CTRL_REF_BIT  = 2;
  localparam logic [2:0]  CTRL_RST      = 3'h0;
  localparam int unsigned ST_DEACT_BIT  = 4;
  localparam int unsigned ST_REFUSE_BIT = 5;

  typedef enum logic [3:0] {
    ST_HARDWARE_RESET_STATE, ST_BOOT, ST_SOFTWARE_RESET_STATE, ST_STANDBY, ST_POWER_DOWN,
    ST_WAKE, ST_PLL_LOCK, ST_INTEGRATE, ST_STREAM
  } spms_mode_e;
endpackage

//--- hdl/spms_if.sv
// Purpose: Pins and control bus between host and sensor
// Assumes: All signals driven from flops on one clock
// Notes:   Reference clock carried as a one-cycle tick
`timescale 1ns/10ps
interface spms_if;
  logic        hard_reset_pin_n;
  logic        power_down_pin_n;
  logic        reference_clock_in;
  logic        ctl_wr;
  logic        ctl_rd;
  logic [15:0] ctl_addr;
  logic [7:0]  ctl_wdata;
  logic [7:0]  ctl_rdata;
  logic        frame_sync;
  logic        pad_val;
  logic        pad_oe;

  modport device (
    input  hard_reset_pin_n, power_down_pin_n, reference_clock_in,
    input  ctl_wr, ctl_rd, ctl_addr, ctl_wdata,
    output ctl_rdata, frame_sync, pad_val, pad_oe
  );
  modport host (
    output hard_reset_pin_n, power_down_pin_n, reference_clock_in,
    output ctl_wr, ctl_rd, ctl_addr, ctl_wdata,
    input  ctl_rdata, frame_sync, pad_val, pad_oe
  );
endinterface

//--- hdl/spms_tick_cnt.sv
// Purpose: Down counter of enable ticks with done pulse
// Assumes: start_i reloads at any time
// Notes:   done_o is one cycle after the last tick
`timescale 1ns/10ps
module spms_tick_cnt #(
  parameter int unsigned W = 20
) (
  input  logic         clk_i,
  input  logic         rst_i,
  input  logic         start_i,
  input  logic [W-1:0] len_i,
  input  logic         tick_i,
  output logic         busy_o,
  output logic         done_o
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_r  <= len_i;
        busy_o <= 1'b1;
      end else if (busy_o && tick_i) begin
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r <= W'(1)) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule

//--- hdl/spms_host.sv
// Purpose: Host end driving sensor pins and control bus
// Assumes: Plain register port, read data one cycle later
// Notes:   Refused bus requests set a sticky status bit
`timescale 1ns/10ps
module spms_host
  import spms_pkg::*;
#(
  parameter int unsigned REF_DIV        = REF_CLK_DIV,
  parameter int unsigned BOOT_WAIT      = BOOT_REF_CYC,
  parameter int unsigned WAKE_WAIT      = WAKE_REF_CYC,
  parameter int unsigned SWRST_WAIT_CLK = SWRST_WAIT_CYC
) (
  input  logic        clk_i,
  input  logic        rst_i,
  input  logic [7:0]  addr_i,
  input  logic [31:0] wdata_i,
  input  logic        wr_i,
  input  logic        rd_i,
  output logic [31:0] rdata_o,
  spms_if.host        link
);
  logic [2:0]       ctrl_r;
  logic [15:0]      bus_addr_r;
  logic [7:0]       rd_byte_r;
  logic [7:0]       div_cnt_r;
  logic             access_ok_r;
  logic             stream_req_r;
  logic             idle_r;
  logic             hi_ok_r;
  logic             deact_r;
  logic             refused_r;
  logic             rd_pend_r;
  logic             rst_nxt;
  logic             pd_nxt;
  logic             rst_rise;
  logic             pd_rise;
  logic             wait_start;
  logic             wait_done;
  logic             swrst_busy;
  logic             swrst_go;
  logic             wr_req;
  logic             rd_req;
  logic             wr_ok;
  logic [CNT_W-1:0] wait_len;

  // Reset released only with the reference clock running
  assign rst_nxt  = ctrl_r[CTRL_REL_BIT] && ctrl_r[CTRL_REF_BIT];
  // Power-down pin kept high unless idle in standby
  assign pd_nxt   = ctrl_r[CTRL_PWR_BIT] || !idle_r || stream_req_r;
  assign rst_rise = rst_nxt && !link.hard_reset_pin_n;
  assign pd_rise  = pd_nxt && !link.power_down_pin_n && link.hard_reset_pin_n;
  assign wait_start = rst_rise || pd_rise;
  // One extra tick covers the device settling into standby
  assign wait_len = pd_rise ? CNT_W'(WAKE_WAIT + 1) : CNT_W'(BOOT_WAIT + 1);
  assign wr_req   = wr_i && (addr_i == HC_WDATA_OFS);
  assign rd_req   = wr_i && (addr_i == HC_RDATA_OFS);
  assign wr_ok    = access_ok_r && !swrst_busy
                    && !(bus_addr_r == STREAM_REG_ADDR && wdata_i[STREAM_EN_BIT] && !hi_ok_r);
  assign swrst_go = wr_req && wr_ok && (bus_addr_r == SWRST_REG_ADDR) && wdata_i[SWRST_BIT];

  spms_tick_cnt #(
    .W (CNT_W)
  ) u_access_wait (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (wait_start),
    .len_i   (wait_len),
    .tick_i  (link.reference_clock_in),
    .busy_o  (),
    .done_o  (wait_done)
  );

  spms_tick_cnt #(
    .W (CNT_W)
  ) u_swrst_wait (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (swrst_go),
    .len_i   (CNT_W'(SWRST_WAIT_CLK)),
    .tick_i  (1'b1),
    .busy_o  (swrst_busy),
    .done_o  ()
  );

  // Reference clock divider and pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_r               <= 8'h00;
      link.reference_clock_in <= 1'b0;
      link.hard_reset_pin_n   <= 1'b0;
      link.power_down_pin_n   <= 1'b0;
    end else begin
      div_cnt_r               <= (div_cnt_r == 8'(REF_DIV - 1)) ? 8'h00 : div_cnt_r + 8'h01;
      link.reference_clock_in <= ctrl_r[CTRL_REF_BIT] && (div_cnt_r == 8'(REF_DIV - 1));
      link.hard_reset_pin_n   <= rst_nxt;
      link.power_down_pin_n   <= pd_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !link.hard_reset_pin_n || !link.power_down_pin_n || wait_start) begin
      access_ok_r <= 1'b0;
    end else if (wait_done) begin
      access_ok_r <= 1'b1;
    end
  end

  // Host registers and stream bookkeeping
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r       <= CTRL_RST;
      bus_addr_r   <= 16'h0000;
      stream_req_r <= 1'b0;
      idle_r       <= 1'b1;
      hi_ok_r      <= 1'b1;
    end else begin
      if (wr_i && addr_i == HC_CTRL_OFS) begin
        ctrl_r <= wdata_i[2:0];
      end
      if (wr_i && addr_i == HC_ADDR_OFS) begin
        bus_addr_r <= wdata_i[15:0];
      end
      if (!link.hard_reset_pin_n || swrst_go) begin
        stream_req_r <= 1'b0;
        idle_r       <= 1'b1;
        hi_ok_r      <= 1'b1;
      end else begin
        if (link.frame_sync && !stream_req_r) begin
          idle_r <= 1'b1;
        end
        if (wr_req && wr_ok && bus_addr_r == STREAM_REG_ADDR) begin
          stream_req_r <= wdata_i[STREAM_EN_BIT];
          if (wdata_i[STREAM_EN_BIT]) begin
            idle_r  <= 1'b0;
            hi_ok_r <= 1'b0;
          end
        end else if (wr_req && wr_ok && bus_addr_r >= HIGH_REGION_ADDR) begin
          hi_ok_r <= 1'b1;
        end
      end
    end
  end

  // Sticky flags; a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deact_r   <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (wr_i && addr_i == HC_STATUS_OFS) begin
        deact_r   <= deact_r && !wdata_i[ST_DEACT_BIT];
        refused_r <= refused_r && !wdata_i[ST_REFUSE_BIT];
      end
      if (link.frame_sync && !stream_req_r) begin
        deact_r <= 1'b1;
      end
      if ((wr_req && !wr_ok) || (rd_req && !(access_ok_r && !swrst_busy))) begin
        refused_r <= 1'b1;
      end
    end
  end

  // Control bus strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.ctl_wr    <= 1'b0;
      link.ctl_rd    <= 1'b0;
      link.ctl_addr  <= 16'h0000;
      link.ctl_wdata <= 8'h00;
      rd_pend_r      <= 1'b0;
      rd_byte_r      <= 8'h00;
    end else begin
      link.ctl_wr <= wr_req && wr_ok;
      link.ctl_rd <= rd_req && access_ok_r && !swrst_busy;
      rd_pend_r   <= link.ctl_rd;
      if (wr_req || rd_req) begin
        link.ctl_addr <= bus_addr_r;
      end
      if (wr_req) begin
        link.ctl_wdata <= wdata_i[7:0];
      end
      if (rd_pend_r) begin
        rd_byte_r <= link.ctl_rdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        case (addr_i)
          HC_CTRL_OFS:   rdata_o[2:0]  <= ctrl_r;
          HC_ADDR_OFS:   rdata_o[15:0] <= bus_addr_r;
          HC_RDATA_OFS:  rdata_o[7:0]  <= rd_byte_r;
          HC_STATUS_OFS: rdata_o[5:0]  <= {refused_r, deact_r, stream_req_r,
                                           hi_ok_r, swrst_busy, access_ok_r};
          default:       rdata_o       <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

//--- tb/spms_props.sv
// Purpose: Concurrent checks on the host to sensor pins and control bus
// Assumes: One clock, synchronous reset, reference clock as a tick
// Notes:   Tick counts follow the shortened bench parameters
`timescale 1ns/10ps
module spms_props
  import spms_pkg::*;
#(
  parameter int unsigned BOOT  = 20,
  parameter int unsigned WAKE  = 30,
  parameter int unsigned PLL   = 10,
  parameter int unsigned INTEG = 4,
  parameter int unsigned FRAME = 16
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        hard_reset_pin_n,
  input wire logic        power_down_pin_n,
  input wire logic        reference_clock_in,
  input wire logic        ctl_wr,
  input wire logic        ctl_rd,
  input wire logic [15:0] ctl_addr,
  input wire logic [7:0]  ctl_wdata,
  input wire logic [7:0]  ctl_rdata,
  input wire logic        frame_sync,
  input wire logic        pad_val,
  input wire logic        pad_oe
);
  logic [15:0] cnt_r;
  logic [15:0] tks_r;
  logic        wk_r;
  logic        pen_r;
  logic        pvl_r;
  logic        sw_wr;
  logic        st_wr;

  assign sw_wr = ctl_wr && ctl_addr == SWRST_REG_ADDR && ctl_wdata[SWRST_BIT];
  assign st_wr = ctl_wr && ctl_addr == STREAM_REG_ADDR && ctl_wdata[STREAM_EN_BIT];

  // Ticks since both pins high
  always_ff @(posedge clk_i) begin
    if (rst_i || !hard_reset_pin_n || !power_down_pin_n) cnt_r <= 16'h0000;
    else if (reference_clock_in && cnt_r != 16'hFFFF) cnt_r <= cnt_r + 16'h0001;
  end
  // Ticks since stream start
  always_ff @(posedge clk_i) begin
    if (rst_i || st_wr) tks_r <= 16'h0000;
    else if (reference_clock_in && tks_r != 16'hFFFF) tks_r <= tks_r + 16'h0001;
  end
  // Last exit was a wake
  always_ff @(posedge clk_i) begin
    if (rst_i || !hard_reset_pin_n) wk_r <= 1'b0;
    else if ($fell(power_down_pin_n)) wk_r <= 1'b1;
  end
  // Shadow of the pad drive bits
  always_ff @(posedge clk_i) begin
    if (rst_i || !hard_reset_pin_n || sw_wr || $rose(power_down_pin_n)) begin
      pen_r <= 1'b0;
      pvl_r <= 1'b0;
    end else if (ctl_wr && ctl_addr == PAD_REG_ADDR) begin
      pen_r <= ctl_wdata[PAD_EN_BIT];
      pvl_r <= ctl_wdata[PAD_VAL_BIT];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_rst_quiet;
    !hard_reset_pin_n && !$past(hard_reset_pin_n) |-> !pad_oe && !frame_sync && ctl_rdata == 8'h00;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("pins active in reset");
  property p_pd_sync;
    !power_down_pin_n |-> !frame_sync;
  endproperty
  a_pd_sync: assert property (p_pd_sync) else $error("frame sync in power down");
  property p_pd_pad;
    !power_down_pin_n && !$past(power_down_pin_n, 2) && hard_reset_pin_n
      && $past(hard_reset_pin_n, 2) |-> pad_oe == pen_r && (!pen_r || pad_val == pvl_r);
  endproperty
  a_pd_pad: assert property (p_pd_pad) else $error("pad level wrong in power down");
  property p_boot;
    (ctl_wr || ctl_rd) && !wk_r |-> cnt_r >= BOOT;
  endproperty
  a_boot: assert property (p_boot) else $error("bus access before boot wait");
  property p_wake;
    (ctl_wr || ctl_rd) && wk_r |-> cnt_r >= WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("bus access before wake wait");
  property p_first;
    frame_sync |-> tks_r >= PLL + INTEG + FRAME - 2;
  endproperty
  a_first: assert property (p_first) else $error("frame too early after start");
  property p_swrst;
    sw_wr |=> !frame_sync [*8];
  endproperty
  a_swrst: assert property (p_swrst) else $error("frame sync after soft reset");
  property p_fs_gap;
    frame_sync |=> !frame_sync [*8];
  endproperty
  a_fs_gap: assert property (p_fs_gap) else $error("frame sync pulses too close");
endmodule

//--- tb/spms_tb.sv
// Purpose: Bench joining host and sensor ends over the pin interface
// Assumes: Shortened tick counts, reference tick every 4 clocks
// Notes:   Each scenario task drives and judges on its own
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module spms_tb;
  import spms_pkg::*;
  localparam int unsigned BT = 20;
  localparam int unsigned WT = 30;
  localparam int unsigned PT = 10;
  localparam int unsigned RD = 4;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic [7:0]  addr_i  = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [31:0] rdata_o;
  logic [31:0] d;
  spms_mode_e  mode_o;
  logic        pll_on_o, analog_on_o, pll_clk_sel_o;
  logic        regulator_lp_o, clocks_gated_o, video_valid_o;
  int          mismatches = 0;
  int          tests_run  = 0;
  int          n;
  spms_if link ();

  always #5 clk_i = ~clk_i;

  spms_host #(.REF_DIV(RD), .BOOT_WAIT(BT), .WAKE_WAIT(WT), .SWRST_WAIT_CLK(200)) i_spms_host (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .link(link));
  spms_sensor #(.BOOT_TICKS(BT), .WAKE_TICKS(WT), .PLL_TICKS(PT), .INTEG_TICKS(4),
    .FRAME_TICKS(16)) i_spms_sensor (
    .clk_i(clk_i), .rst_i(rst_i), .link(link), .mode_o(mode_o), .pll_on_o(pll_on_o),
    .analog_on_o(analog_on_o), .pll_clk_sel_o(pll_clk_sel_o), .regulator_lp_o(regulator_lp_o),
    .clocks_gated_o(clocks_gated_o), .video_valid_o(video_valid_o));
  spms_props #(.BOOT(BT), .WAKE(WT), .PLL(PT), .INTEG(4), .FRAME(16)) i_spms_props (
    .clk_i(clk_i), .rst_i(rst_i), .hard_reset_pin_n(link.hard_reset_pin_n),
    .power_down_pin_n(link.power_down_pin_n), .reference_clock_in(link.reference_clock_in),
    .ctl_wr(link.ctl_wr), .ctl_rd(link.ctl_rd), .ctl_addr(link.ctl_addr),
    .ctl_wdata(link.ctl_wdata), .ctl_rdata(link.ctl_rdata), .frame_sync(link.frame_sync),
    .pad_val(link.pad_val), .pad_oe(link.pad_oe));

  task automatic hw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic hr(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  task automatic wait_ok();
    logic [31:0] s;
    s = 32'h0000_0000;
    for (int i = 0; i < 3000 && !(s[0] === 1'b1 && s[1] === 1'b0); i++) hr(HC_STATUS_OFS, s);
  endtask
  task automatic bw(input logic [15:0] a, input logic [7:0] v);
    wait_ok();
    hw(HC_ADDR_OFS, {16'h0000, a});
    hw(HC_WDATA_OFS, {24'h00_0000, v});
  endtask
  task automatic br(input logic [15:0] a);
    wait_ok();
    hw(HC_ADDR_OFS, {16'h0000, a});
    hw(HC_RDATA_OFS, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    hr(HC_RDATA_OFS, d);
  endtask
  task automatic wm(input spms_mode_e m, input int lim);
    n = 0;
    while (mode_o !== m && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask

  task automatic t_boot();
    hw(HC_CTRL_OFS, 32'h0000_0006);
    repeat (100) @(posedge clk_i);
    #1;
    `CHK(mode_o, ST_HARDWARE_RESET_STATE)
    `CHK(link.pad_oe, 1'b0)
    hw(HC_CTRL_OFS, 32'h0000_0007);
    wm(ST_STANDBY, 500);
    `CHK(mode_o, ST_STANDBY)
    `CHK(n >= BT * RD - 8 && n <= BT * RD + 12, 1'b1)
  endtask
  task automatic t_pdown();
    bw(PAD_REG_ADDR, 8'h30);
    hw(HC_CTRL_OFS, 32'h0000_0005);
    wm(ST_POWER_DOWN, 50);
    `CHK(mode_o, ST_POWER_DOWN)
    `CHK({regulator_lp_o, clocks_gated_o, link.pad_oe, link.pad_val}, 4'hF)
    hw(HC_CTRL_OFS, 32'h0000_0007);
    wm(ST_STANDBY, 1000);
    `CHK(n >= WT * RD - 8, 1'b1)
    br(PAD_REG_ADDR);
    `CHK(d[7:0], 8'h00)
  endtask
  task automatic t_stream();
    bw(HIGH_REGION_ADDR, 8'h00);
    bw(STREAM_REG_ADDR, 8'h01);
    wm(ST_PLL_LOCK, 50);
    `CHK({pll_on_o, analog_on_o, pll_clk_sel_o}, 3'h6)
    wm(ST_INTEGRATE, 200);
    `CHK(n >= PT * RD - 6 && n <= PT * RD + 6, 1'b1)
    `CHK(pll_clk_sel_o, 1'b1)
    wm(ST_STREAM, 100);
    `CHK(video_valid_o, 1'b1)
    bw(STREAM_REG_ADDR, 8'h00);
    n = 0;
    while (link.frame_sync !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK(mode_o, ST_STANDBY)
    @(posedge clk_i);
    #1;
    `CHK({pll_on_o, analog_on_o, pll_clk_sel_o}, 3'h0)
    hr(HC_STATUS_OFS, d);
    `CHK(d[ST_DEACT_BIT], 1'b1)
    hw(HC_STATUS_OFS, 32'h0000_0020);
    bw(STREAM_REG_ADDR, 8'h01);
    hr(HC_STATUS_OFS, d);
    `CHK(d[ST_REFUSE_BIT], 1'b1)
    `CHK(mode_o, ST_STANDBY)
  endtask
  task automatic t_swrst();
    hw(HC_STATUS_OFS, 32'h0000_0020);
    bw(HIGH_REGION_ADDR, 8'h00);
    bw(STREAM_REG_ADDR, 8'h01);
    wm(ST_STREAM, 300);
    bw(SWRST_REG_ADDR, 8'h01);
    wm(ST_STANDBY, 20);
    `CHK(mode_o, ST_STANDBY)
    hr(HC_STATUS_OFS, d);
    `CHK(d[1], 1'b1)
    hw(HC_WDATA_OFS, 32'h0000_0000);
    hr(HC_STATUS_OFS, d);
    `CHK(d[ST_REFUSE_BIT], 1'b1)
    br(STREAM_REG_ADDR);
    `CHK(d[7:0], 8'h00)
    br(MODE_REG_ADDR);
    `CHK(d[3:0], ST_STANDBY)
  endtask
  task automatic t_prio();
    hw(HC_CTRL_OFS, 32'h0000_0005);
    wm(ST_POWER_DOWN, 50);
    hw(HC_CTRL_OFS, 32'h0000_0004);
    wm(ST_HARDWARE_RESET_STATE, 5);
    `CHK(mode_o, ST_HARDWARE_RESET_STATE)
    `CHK(link.pad_oe, 1'b0)
  endtask

  task automatic summarize();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_boot();
    t_pdown();
    t_stream();
    t_swrst();
    t_prio();
    summarize();
  end
  initial begin
    #1000000;
    mismatches++;
    summarize();
  end
endmodule
